// file: twi_stretch_pkg.sv
/*
 * Constants and types of the two-wire stretch and acknowledge block.
 * Assumes a 50 MHz system clock.
 */
package twi_stretch_pkg;

   // Baud rollover in system clocks (reload value left to the integrator)
   localparam logic [7:0] BAUD_ROLLOVER_CYCLES = 8'h0A;

   // Byte framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BITS_PER_UNIT = 4'h9;
   localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
   // The fall that closes a Start wraps this to zero
   localparam logic [3:0] BIT_COUNT_START = 4'hF;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Line levels after reset: both lines released, read as high
   localparam logic [1:0] LINES_IDLE = 2'h3;
   localparam logic [1:0] DRIVE_NONE = 2'h0;

   // Acknowledge sequence, Gray coded from idle to end; the return to idle flips two bits
   typedef enum logic [2:0] {
      ACK_IDLE = 3'b000,
      ACK_LOW = 3'b001,
      ACK_RISE = 3'b011,
      ACK_HIGH = 3'b010,
      ACK_END = 3'b110
   } ack_state_t;

endpackage

// file: line_sync.sv
/*
 * Two-flop synchroniser for level signals.
 * Assumes inputs from another clock domain or a pin.
 */
`timescale 1ns/100ps
module line_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stage_one <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule // line_sync

// file: baud_timer.sv
/*
 * One-shot rollover timer.
 * Assumes one-cycle start and stop pulses on the same clock.
 */
`timescale 1ns/100ps
module baud_timer
   import twi_stretch_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic start,
   input wire logic stop,
   // Status
   output logic running,
   output logic done
);

   logic [7:0] count;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count <= 8'h00;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (stop) begin
            running <= 1'b0;
         end else if (start) begin
            count <= BAUD_ROLLOVER_CYCLES - 8'h01;
            running <= 1'b1;
         end else if (running) begin
            if (count == 8'h00) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 8'h01;
            end
         end
      end
   end

endmodule // baud_timer

// file: twi_stretch_core.sv
/*
 * Two-wire slave port: framing, arbitration, clock stretching and the
 * master acknowledge sequence.
 * Assumes address matching outside; line sampling and drive on link_clk.
 */
//
// Behaviour
// - Track Start and Stop; bus busy until Stop.
// - Sampled SDA differs from driven level: release SDA.
// - Lost arbitration releases SCL too; retry after Stop.
// - Lower address wins; same address arbitrates through data.
// - Whole bytes, most significant bit first.
// - Nine-bit units; sender frees SDA after eighth fall.
// - SDA moves while SCL low; SDA edge with SCL high is a condition.
// - Enabled pins are open-drain with output data zero.
// - Clearing clock-release holds SCL once low; setting releases it.
// - Read request clears clock-release after address acknowledge.
// - Stretch enable stretches after every byte's acknowledge.
// - Buffer-full never affects stretching.
// - Ten-bit address update holds SCL until address register write.
// - Address hold clears clock-release at eighth fall of match.
// - Data hold clears clock-release at eighth fall of data.
// - SCL driven only after it is sampled low.
// - Held SCL stays low until released here and elsewhere.
// - Idle active master keeps SCL low; waits for real rise.
// - Acknowledge sequence pulls SCL low, drives acknowledge data.
// - Count a period, release SCL, once high count again, pull low.
// - Sequence end clears enable, stops timer, goes idle.
// - Buffer write during acknowledge dropped; collision flag set.
`timescale 1ns/100ps
module twi_stretch_core
   import twi_stretch_pkg::*;
(
   // System clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Line clock and its reset
   input wire logic link_clk,
   input wire logic link_rst_b,
   // Bus pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_b,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b,
   // Configuration
   input wire logic port_enable_bit,
   input wire logic stretch_enable_bit,
   input wire logic address_hold_enable,
   input wire logic data_hold_enable,
   input wire logic ten_bit_mode,
   input wire logic master_active,
   input wire logic address_match,
   input wire logic ack_data_value,
   // Software strobes
   input wire logic clock_release_set,
   input wire logic clock_release_clear,
   input wire logic ack_sequence_start,
   input wire logic address_register_write,
   input wire logic shift_buffer_write,
   input wire logic [7:0] shift_buffer_wdata,
   input wire logic shift_buffer_read,
   input wire logic write_collision_clear,
   input wire logic arbitration_lost_clear,
   // Status
   output logic clock_release_bit,
   output logic ack_sequence_enable,
   output logic address_update_flag,
   output logic buffer_full_flag,
   output logic write_collision_flag,
   output logic arbitration_lost,
   output logic bus_busy,
   output logic read_request,
   output logic [7:0] shift_buffer
);

   ////////////////////////////////////////////////////////////////////////
   // Line domain: sampling and pin drive

   logic [1:0] link_lines;
   logic [1:0] link_drive;
   logic [1:0] drive_req;

   line_sync #(.WIDTH(2), .RESET_VALUE(LINES_IDLE)) u_link_in (
      .clk(link_clk),
      .rst_b(link_rst_b),
      .async_in({scl_in, sda_in}),
      .sync_out(link_lines)
   );

   line_sync #(.WIDTH(2), .RESET_VALUE(DRIVE_NONE)) u_link_drive (
      .clk(link_clk),
      .rst_b(link_rst_b),
      .async_in(drive_req),
      .sync_out(link_drive)
   );

   // Registered pin drive; data always zero so the pins only ever sink
   always_ff @(posedge link_clk) begin
      if (!link_rst_b) begin
         scl_oe_b <= 1'b1;
         sda_oe_b <= 1'b1;
      end else begin
         scl_oe_b <= !(link_drive[1] && port_enable_bit);
         sda_oe_b <= !(link_drive[0] && port_enable_bit);
      end
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // System domain: line events

   logic [1:0] lines;
   logic scl;
   logic sda;
   logic scl_prev;
   logic sda_prev;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   line_sync #(.WIDTH(2), .RESET_VALUE(LINES_IDLE)) u_sys_in (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(link_lines),
      .sync_out(lines)
   );

   assign scl = lines[1];
   assign sda = lines[0];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl;
         sda_prev <= sda;
      end
   end

   assign scl_rise = scl && !scl_prev;
   assign scl_fall = !scl && scl_prev;
   // SDA moving while SCL stays high marks Start or Stop
   assign start_cond = scl && scl_prev && sda_prev && !sda;
   assign stop_cond = scl && scl_prev && !sda_prev && sda;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bus_busy <= 1'b0;
      end else if (!port_enable_bit || stop_cond) begin
         bus_busy <= 1'b0;
      end else if (start_cond) begin
         bus_busy <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte framing

   logic [3:0] bit_count;
   logic address_byte;
   logic addressed;
   logic tx_mode;
   logic [7:0] rx_shift;
   logic [7:0] tx_shift;
   logic eighth_fall;
   logic ninth_fall;
   logic in_ack_slot;
   logic rx_is_read;
   logic master_nack;

   assign eighth_fall = scl_fall && (bit_count == BITS_PER_BYTE - 4'h1);
   assign ninth_fall = scl_fall && (bit_count == BITS_PER_BYTE);
   assign in_ack_slot = (bit_count == BITS_PER_BYTE);
   assign rx_is_read = rx_shift[0];

   always_ff @(posedge clk) begin
      if (!rst_b || !port_enable_bit) begin
         bit_count <= BIT_COUNT_RESET;
         address_byte <= 1'b0;
      end else if (start_cond) begin
         bit_count <= BIT_COUNT_START;
         address_byte <= 1'b1;
      end else if (stop_cond) begin
         address_byte <= 1'b0;
      end else if (scl_fall) begin
         if (bit_count == BITS_PER_UNIT - 4'h1) begin
            bit_count <= BIT_COUNT_RESET;
            address_byte <= 1'b0;
         end else begin
            bit_count <= bit_count + 4'h1;
         end
      end
   end

   // Received bits enter at the bottom, so the first bit ends up on top
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rx_shift <= BYTE_RESET;
      end else if (scl_rise && !in_ack_slot) begin
         rx_shift <= {rx_shift[6:0], sda};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !port_enable_bit || start_cond || stop_cond) begin
         addressed <= 1'b0;
      end else if (eighth_fall && address_byte) begin
         addressed <= address_match;
      end
   end

   // Master acknowledge seen on the ninth rise while sending
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         master_nack <= 1'b0;
      end else if (scl_rise && in_ack_slot) begin
         master_nack <= sda;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !port_enable_bit || start_cond || stop_cond) begin
         tx_mode <= 1'b0;
         read_request <= 1'b0;
      end else if (ninth_fall && address_byte && addressed) begin
         tx_mode <= rx_is_read;
         read_request <= rx_is_read;
      end else if (ninth_fall && tx_mode && master_nack) begin
         tx_mode <= 1'b0;
      end else if (arbitration_lost) begin
         tx_mode <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift buffer and software flags

   logic ack_busy;

   assign ack_busy = ack_sequence_enable;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shift_buffer <= BYTE_RESET;
      end else if (ninth_fall && addressed && !tx_mode && !address_byte) begin
         shift_buffer <= rx_shift;
      end else if (shift_buffer_write && !ack_busy) begin
         shift_buffer <= shift_buffer_wdata;
      end
   end

   // Set wins over clear for every hardware-set flag
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         buffer_full_flag <= 1'b0;
      end else if (ninth_fall && addressed && !tx_mode && !address_byte) begin
         buffer_full_flag <= 1'b1;
      end else if (shift_buffer_read) begin
         buffer_full_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         write_collision_flag <= 1'b0;
      end else if (shift_buffer_write && ack_busy) begin
         write_collision_flag <= 1'b1;
      end else if (write_collision_clear) begin
         write_collision_flag <= 1'b0;
      end
   end

   // Outgoing byte, most significant bit first, advanced on each fall
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tx_shift <= BYTE_RESET;
      end else if (ninth_fall) begin
         tx_shift <= shift_buffer;
      end else if (shift_buffer_write && !ack_busy && !clock_release_bit) begin
         tx_shift <= shift_buffer_wdata;
      end else if (scl_fall && tx_mode && !in_ack_slot) begin
         tx_shift <= {tx_shift[6:0], 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration

   logic sda_drive_low;
   logic sda_released_high;

   assign sda_released_high = tx_mode && !in_ack_slot && tx_shift[7];

   // Checked only where the line should float high
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         arbitration_lost <= 1'b0;
      end else if (scl_rise && sda_released_high && !sda) begin
         arbitration_lost <= 1'b1;
      end else if (arbitration_lost_clear) begin
         arbitration_lost <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock-release bit and stretching

   logic hw_release_clear;
   logic scl_hold;

   // Buffer-full plays no part here on purpose
   assign hw_release_clear =
      (ninth_fall && address_byte && addressed && rx_is_read) ||
      (ninth_fall && addressed && stretch_enable_bit) ||
      (eighth_fall && address_byte && address_match &&
       address_hold_enable) ||
      (eighth_fall && !address_byte && addressed && !tx_mode &&
       data_hold_enable);

   // A hardware stretch request beats a simultaneous software release
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clock_release_bit <= 1'b1;
      end else if (hw_release_clear || clock_release_clear) begin
         clock_release_bit <= 1'b0;
      end else if (clock_release_set) begin
         clock_release_bit <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !port_enable_bit) begin
         address_update_flag <= 1'b0;
      end else if (ninth_fall && address_byte && addressed && ten_bit_mode) begin
         address_update_flag <= 1'b1;
      end else if (address_register_write) begin
         address_update_flag <= 1'b0;
      end
   end

   // Grab SCL only once it already reads low, so high time is never cut
   always_ff @(posedge clk) begin
      if (!rst_b || !port_enable_bit) begin
         scl_hold <= 1'b0;
      end else if (clock_release_bit && !address_update_flag) begin
         scl_hold <= 1'b0;
      end else if (!scl || scl_fall) begin
         scl_hold <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acknowledge sequence

   ack_state_t ack_state;
   ack_state_t next_ack_state;
   logic baud_start;
   logic baud_stop;
   logic baud_running;
   logic baud_done;
   logic ack_sda_low;

   baud_timer u_baud (
      .clk(clk),
      .rst_b(rst_b),
      .start(baud_start),
      .stop(baud_stop),
      .running(baud_running),
      .done(baud_done)
   );

   always_comb begin
      next_ack_state = ack_state;
      baud_start = 1'b0;
      baud_stop = 1'b0;
      case (ack_state)
         ACK_IDLE: begin
            if (ack_sequence_start && port_enable_bit) begin
               next_ack_state = ACK_LOW;
               baud_start = 1'b1;
            end
         end
         ACK_LOW: begin
            if (baud_done) begin
               next_ack_state = ACK_RISE;
            end
         end
         ACK_RISE: begin
            // Another device may still stretch; wait for the real rise
            if (scl) begin
               next_ack_state = ACK_HIGH;
               baud_start = 1'b1;
            end
         end
         ACK_HIGH: begin
            if (baud_done) begin
               next_ack_state = ACK_END;
            end
         end
         ACK_END: begin
            next_ack_state = ACK_IDLE;
            baud_stop = 1'b1;
         end
         default: begin
            next_ack_state = ACK_IDLE;
            baud_stop = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !port_enable_bit) begin
         ack_state <= ACK_IDLE;
      end else begin
         ack_state <= next_ack_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !port_enable_bit) begin
         ack_sequence_enable <= 1'b0;
      end else if (ack_state == ACK_IDLE && ack_sequence_start) begin
         ack_sequence_enable <= 1'b1;
      end else if (ack_state == ACK_END) begin
         ack_sequence_enable <= 1'b0;
      end
   end

   // Acknowledge value latched by software beforehand: low means ACK
   assign ack_sda_low = (ack_state != ACK_IDLE) && !ack_data_value;

   ////////////////////////////////////////////////////////////////////////
   // Line drive requests

   logic scl_drive_low;
   logic slave_ack_low;

   assign slave_ack_low = in_ack_slot && !tx_mode &&
      ((address_byte && address_match) || (!address_byte && addressed));

   // Transmit data changes on the fall, so SDA only moves with SCL low
   assign sda_drive_low = !arbitration_lost &&
      (ack_sda_low ||
       slave_ack_low ||
       (tx_mode && !in_ack_slot && !tx_shift[7]));

   assign scl_drive_low = !arbitration_lost &&
      (scl_hold ||
       ack_state == ACK_LOW || ack_state == ACK_END ||
       (master_active && ack_state == ACK_IDLE && !bus_busy));

   assign drive_req = {scl_drive_low, sda_drive_low};

endmodule // twi_stretch_core

// file: twi_stretch_props.sv
/*
 * Port checker for twi_stretch_core.
 * Assumes a bind into the core; pin enables lag a few cycles.
 */
`timescale 1ns/100ps
module twi_stretch_props (
   // Clock and reset
   input logic clk,
   input logic rst_b,
   // Pins
   input logic scl_out,
   input logic scl_oe_b,
   input logic sda_out,
   input logic sda_oe_b,
   // Controls
   input logic master_active,
   input logic ack_data_value,
   input logic ack_sequence_start,
   input logic shift_buffer_write,
   input logic clock_release_set,
   input logic clock_release_clear,
   input logic address_register_write,
   // Status
   input logic clock_release_bit,
   input logic ack_sequence_enable,
   input logic address_update_flag,
   input logic write_collision_flag,
   input logic arbitration_lost,
   input logic bus_busy,
   input logic [7:0] shift_buffer
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Counters stand in for long repetitions
   logic [7:0] ack_cnt;
   logic [3:0] rel_cnt;
   always_ff @(posedge clk) begin
      if (!rst_b || !ack_sequence_enable) begin
         ack_cnt <= 8'h00;
      end else if (ack_cnt != 8'hFF) begin
         ack_cnt <= ack_cnt + 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b || !clock_release_bit || address_update_flag ||
            ack_sequence_enable || master_active) begin
         rel_cnt <= 4'h0;
      end else if (rel_cnt != 4'hF) begin
         rel_cnt <= rel_cnt + 4'h1;
      end
   end
   sequence ack_go_s;
      ack_sequence_start && !ack_sequence_enable;
   endsequence
   sequence ack_on_s;
      $rose(ack_sequence_enable);
   endsequence
   pins_zero_a: assert property (!scl_out && !sda_out)
      else $error("pin data not zero");
   ack_start_a: assert property (ack_go_s |=> ack_sequence_enable)
      else $error("ack not started");
   ack_drive_a: assert property (ack_on_s |-> ##[1:9]
      (!scl_oe_b && sda_oe_b == ack_data_value))
      else $error("ack pins wrong");
   ack_time_a: assert property ($fell(ack_sequence_enable)
      |-> ack_cnt >= 8'h14) else $error("ack too short");
   ack_bound_a: assert property (ack_cnt < 8'hC8)
      else $error("ack never ended");
   write_collision_flag_set_a: assert property (shift_buffer_write &&
      ack_sequence_enable |=> write_collision_flag && $stable(shift_buffer))
      else $error("write not refused");
   ckp_set_a: assert property (clock_release_set &&
      !clock_release_clear |=> clock_release_bit)
      else $error("release not set");
   ckp_clear_a: assert property (clock_release_clear |=>
      !clock_release_bit) else $error("release not cleared");
   ua_clear_a: assert property (address_register_write |=>
      !address_update_flag) else $error("update not cleared");
   scl_free_a: assert property (rel_cnt >= 4'hC |-> scl_oe_b)
      else $error("clock held");
   master_hold_a: assert property ((master_active && !bus_busy &&
      !ack_sequence_enable)[*8] ##1 master_active[*4] |-> !scl_oe_b)
      else $error("master not holding");
   arb_free_a: assert property (arbitration_lost[*8] ##1
      arbitration_lost[*4] |-> sda_oe_b && scl_oe_b)
      else $error("pins driven after loss");
endmodule // twi_stretch_props

// file: twi_master_model.sv
/*
 * Bus master model: start, stop, byte write, byte read.
 * Assumes pull-ups; the clock stands still between frames.
 */
`timescale 1ns/100ps
module twi_master_model #(
   parameter int HALF_NS = 1000
) (
   // Resolved wires
   input logic scl,
   input logic sda,
   // High pulls the wire low
   output logic scl_pull,
   output logic sda_pull
);
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // High phase waits until every party lets go
   task automatic clk_pulse(output logic seen);
      scl_pull = 1'b0;
      wait (scl === 1'b1);
      #(HALF_NS);
      seen = sda;
      scl_pull = 1'b1;
      #(HALF_NS);
   endtask
   task automatic start_cond();
      wait (scl === 1'b1 && sda === 1'b1);
      sda_pull = 1'b1;
      #(HALF_NS);
      scl_pull = 1'b1;
      #(HALF_NS);
   endtask
   task automatic stop_cond();
      sda_pull = 1'b1;
      #(HALF_NS);
      scl_pull = 1'b0;
      wait (scl === 1'b1);
      #(HALF_NS);
      sda_pull = 1'b0;
      #(HALF_NS);
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         sda_pull = !b[i];
         clk_pulse(x);
      end
      sda_pull = 1'b0;
      clk_pulse(ack);
   endtask
   // Bits set in force_low are pulled low to win arbitration
   task automatic rd_byte(input logic [7:0] force_low, input logic nack,
         output logic [7:0] b);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         sda_pull = force_low[i];
         clk_pulse(b[i]);
      end
      sda_pull = !nack;
      clk_pulse(x);
      sda_pull = 1'b0;
   endtask
endmodule // twi_master_model

// file: twi_stretch_core_tb_top.sv
/*
 * Bench for twi_stretch_core: strobes, ack sequence, slave transfers.
 * Assumes pull-ups on both wires.
 */
`timescale 1ns/100ps
module twi_stretch_core_tb_top;
   import twi_stretch_pkg::*;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic [7:0] st = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic scl_out, scl_oe_b, sda_out, sda_oe_b, scl_pull, sda_pull, ack;
   logic clock_release_bit, ack_sequence_enable, address_update_flag;
   logic buffer_full_flag, write_collision_flag, arbitration_lost;
   logic bus_busy, read_request;
   logic [7:0] shift_buffer, rd;
   logic [1:0] stall;
   wire logic scl_w = scl_oe_b & ~scl_pull;
   wire logic sda_w = sda_oe_b & ~sda_pull;
   int n_fail = 0;
   int check_count = 0;
   int n;
   logic [7:0] t_cfg [6] = '{8'h4D, 8'h51, 8'h43, 8'h41, 8'h41, 8'h41};
   logic [7:0] t_adr [6] = '{8'hA0, 8'hA0, 8'hA0, 8'hA1, 8'hA1, 8'hA0};
   logic [7:0] t_dat [6] = '{8'h6B, 8'h6B, 8'h6B, 8'h96, 8'hFF, 8'h6B};
   logic [7:0] t_msk [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
   // Per case, lowest first: {address stall, data stall}
   logic [23:0] t_st = 24'h044585;
   always #10 clk = ~clk;
   initial begin
      #7;
      forever #16 link_clk = ~link_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(input int i);
      @(posedge clk) #1 st[i] = 1'b1;
      @(posedge clk) #1 st[i] = 1'b0;
   endtask
   task automatic set_cfg(input logic [7:0] v);
      @(posedge clk) #1 cfg = v;
   endtask
   // Frees a byte's first stall, loading the buffer first on a read
   task automatic watch();
      stall = 2'h0;
      repeat (1500) begin
         @(posedge clk) #1;
         if (stall == 2'h0 &&
               (!clock_release_bit || address_update_flag)) begin
            stall = {address_update_flag, !clock_release_bit};
            repeat (20) @(posedge clk);
            check("held scl", scl_oe_b, 1'b0);
            if (read_request === 1'b1) pulse(4);
            pulse(address_update_flag ? 3 : 0);
         end
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   twi_stretch_core u_dut (
      .clk, .rst_b, .link_clk, .link_rst_b(rst_b),
      .scl_in(scl_w), .scl_out, .scl_oe_b, .sda_in(sda_w), .sda_out,
      .sda_oe_b, .port_enable_bit(cfg[0]), .stretch_enable_bit(cfg[1]),
      .address_hold_enable(cfg[2]), .data_hold_enable(cfg[3]),
      .ten_bit_mode(cfg[4]), .master_active(cfg[5]),
      .address_match(cfg[6]), .ack_data_value(cfg[7]),
      .clock_release_set(st[0]), .clock_release_clear(st[1]),
      .ack_sequence_start(st[2]), .address_register_write(st[3]),
      .shift_buffer_write(st[4]), .shift_buffer_wdata(wdata),
      .shift_buffer_read(st[5]), .write_collision_clear(st[6]),
      .arbitration_lost_clear(st[7]), .clock_release_bit,
      .ack_sequence_enable, .address_update_flag, .buffer_full_flag,
      .write_collision_flag, .arbitration_lost, .bus_busy, .read_request,
      .shift_buffer
   );
   twi_master_model u_master (
      .scl(scl_w), .sda(sda_w), .scl_pull, .sda_pull
   );
   initial begin
      #1_000_000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      check("release bit", clock_release_bit, 1'b1);
      check("buffer", shift_buffer, 8'h00);
      check("flags", {write_collision_flag, arbitration_lost,
         address_update_flag, buffer_full_flag}, 8'h00);
      check("pins", {scl_oe_b, sda_oe_b, scl_out, sda_out}, 8'h0C);
      set_cfg(8'h21);
      repeat (20) @(posedge clk);
      check("master hold", scl_w, 1'b0);
      set_cfg(8'h01);
      repeat (20) @(posedge clk);
      pulse(1);
      check("release cleared", clock_release_bit, 1'b0);
      repeat (20) @(posedge clk);
      check("idle scl", scl_w, 1'b1);
      pulse(0);
      check("release set", clock_release_bit, 1'b1);
      wdata = 8'hC3;
      pulse(4);
      check("buffer write", shift_buffer, 8'hC3);
      for (int a = 0; a < 2; a++) begin
         set_cfg({a[0], 7'h01});
         pulse(2);
         check("ack enable", ack_sequence_enable, 1'b1);
         repeat (8) @(posedge clk);
         check("ack pins", {scl_w, sda_w}, {1'b0, a[0]});
         wdata = 8'h5A;
         pulse(4);
         check("collision", write_collision_flag, 1'b1);
         check("kept buffer", shift_buffer, 8'hC3);
         n = 10;
         while (ack_sequence_enable === 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
         end
         check("ack length", n >= 2 * BAUD_ROLLOVER_CYCLES, 1'b1);
         check("ack done", ack_sequence_enable, 1'b0);
         pulse(6);
         repeat (20) @(posedge clk);
      end
      for (int k = 0; k < 6; k++) begin
         set_cfg(t_cfg[k]);
         wdata = t_dat[k];
         u_master.start_cond();
         repeat (20) @(posedge clk);
         check("busy", bus_busy, 1'b1);
         fork
            u_master.wr_byte(t_adr[k], ack);
            watch();
         join
         check("addr ack", ack, 1'b0);
         check("addr stall", stall, t_st[4*k+2+:2]);
         if (t_adr[k][0]) begin
            u_master.rd_byte(t_msk[k], 1'b1, rd);
            check("read", rd, t_dat[k] & ~t_msk[k]);
            check("lost", arbitration_lost, t_msk[k] != 8'h00);
            check("freed", {scl_oe_b, sda_oe_b}, 8'h03);
            pulse(7);
         end else begin
            fork
               u_master.wr_byte(8'h6B, ack);
               watch();
            join
            check("data ack", ack, 1'b0);
            check("data stall", stall, t_st[4*k+:2]);
            check("data", shift_buffer, 8'h6B);
            check("full", buffer_full_flag, 1'b1);
            pulse(5);
         end
         u_master.stop_cond();
         repeat (20) @(posedge clk);
         check("idle", bus_busy, 1'b0);
      end
      report_and_stop();
   end
endmodule // twi_stretch_core_tb_top
bind twi_stretch_core twi_stretch_props u_props (.*);
